// File: rtl/css_consts.vh
// constants for the clock source select block
`ifndef CSS_CONSTS_VH
`define CSS_CONSTS_VH
// ----------------------------------------
// register byte addresses (wishbone, word aligned)
// ----------------------------------------
`define CSS_ADDR_OSC_MODE 20'hfffa0
`define CSS_ADDR_SYS_CLK_SEL 20'hfffa4
`define CSS_ADDR_OSC_STATUS 20'hfffa8
`define CSS_ADDR_FREQ_SEL 20'hfffac
`define CSS_ADDR_SUPPLY_MODE 20'hfffb0
// ----------------------------------------
// field positions
// ----------------------------------------
`define CSS_OM_EXT_CLK_BIT 7
`define CSS_OM_OSC_SEL_BIT 6
`define CSS_OM_GAIN_BIT 0
`define CSS_SC_CPU_STAT_BIT 7
`define CSS_SC_MAIN_STAT_BIT 5
`define CSS_SC_MAIN_SEL_BIT 4
`define CSS_CS_HS_STOP_BIT 7
`define CSS_CS_ONE_BIT 6
`define CSS_CS_HOCO_STOP_BIT 0
`define CSS_SM_ITMR_CLK_BIT 4
`define CSS_OPT_WDT_EN_BIT 4
`define CSS_OPT_WDT_STBY_BIT 0
// ----------------------------------------
// writable masks and reset values
// ----------------------------------------
`define CSS_OM_WMASK 8'hc1
`define CSS_SC_WMASK 8'h10
`define CSS_CS_WMASK 8'h81
`define CSS_SM_WMASK 8'h10
`define CSS_FS_WMASK 8'h0f
`define CSS_OM_RESET 8'h00
`define CSS_SC_RESET 8'h00
`define CSS_CS_RESET 8'hc0
`define CSS_SM_RESET 8'h00
// ----------------------------------------
// on-chip oscillator frequency codes
// ----------------------------------------
`define CSS_FREQ_32 4'h0
`define CSS_FREQ_24 4'h1
`define CSS_FREQ_16 4'h2
`define CSS_FREQ_12 4'h3
`define CSS_FREQ_8 4'h4
`define CSS_FREQ_6 4'h5
`define CSS_FREQ_4 4'h6
`define CSS_FREQ_3 4'h7
`define CSS_FREQ_2 4'h8
`define CSS_FREQ_1 4'h9
// ----------------------------------------
// clock limits in MHz and switch settle time
// ----------------------------------------
`define CSS_XTAL_MAX_MHZ 20
`define CSS_SYS_MAX_MHZ 32
`define CSS_GAIN_LIMIT_MHZ 10
`define CSS_CLK_MHZ 10
`define CSS_SWITCH_NS 300
`define CSS_SWITCH_CYC ((`CSS_SWITCH_NS * `CSS_CLK_MHZ + 999) / 1000)
`endif

// File: rtl/css_clock_source_select.v
// clock source select: oscillator control, main clock switch, register slave
//
// Behaviour
// - crystal stops on stop instruction or stop bit
// - option byte gives initial on-chip frequency
// - after reset, processor runs on-chip oscillator
// - on-chip oscillator stops on stop or bit
// - frequency register overrides option byte choice
// - external clock disabled on stop or bit
// - main select bit chooses high-speed or on-chip
// - low-speed oscillator never clocks the processor
// - low-speed clock only to watchdog, interval timer
// - low-speed runs if watchdog or timer select
// - watchdog-only without standby option stops on halt
// - mode bits decode port, crystal or external
// - gain bit set above 10 MHz crystal
// - mode register takes one 8-bit write only
// - system clock to 32, crystal to 20 MHz
// - status bits read-only, show active source
`timescale 1ns/1ns
`include "css_consts.vh"

module css_clock_source_select #(
    parameter SWITCH_CYC = `CSS_SWITCH_CYC
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [19:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire wb_ack_o,
    output wire wb_err_o,
    input wire [7:0] option_freq_i,
    input wire [7:0] option_wdt_i,
    input wire stop_exec_i,
    input wire halt_exec_i,
    input wire hs_clk_ready_i,
    output wire crystal_osc_en_o,
    output wire crystal_osc_gain_o,
    output wire crystal_in_pin_port_o,
    output wire crystal_out_pin_port_o,
    output wire ext_clk_in_en_o,
    output wire onchip_hs_osc_en_o,
    output wire [3:0] onchip_freq_o,
    output wire lowspeed_osc_en_o,
    output wire lowspeed_to_wdt_en_o,
    output wire lowspeed_to_itmr_en_o,
    output wire main_clk_sel_hs_o,
    output wire cpu_clk_gate_o
);

// ----------------------------------------
// registers
// ----------------------------------------
reg [7:0] osc_mode_reg;
reg osc_mode_written_reg;
reg main_clk_select_reg;
reg main_clk_status_reg;
reg hs_sys_clk_stop_reg;
reg onchip_hs_osc_stop_reg;
reg interval_timer_clk_select_reg;
reg [3:0] freq_sel_reg;
reg freq_loaded_reg;
reg ack_reg;
reg err_reg;
reg [31:0] rdata_reg;
reg [1:0] sw_state_reg;
reg [1:0] sw_state_next;
reg [7:0] sw_cnt_reg;
reg halted_reg;

localparam SW_IDLE = 2'b00;
localparam SW_GATE = 2'b01;
localparam SW_SETTLE = 2'b10;
localparam SW_OPEN = 2'b11;

// ----------------------------------------
// bus decode
// ----------------------------------------
wire bus_req = wb_cyc_i & wb_stb_i & ~ack_reg & ~err_reg;
wire hit_om = (wb_adr_i == `CSS_ADDR_OSC_MODE);
wire hit_sc = (wb_adr_i == `CSS_ADDR_SYS_CLK_SEL);
wire hit_cs = (wb_adr_i == `CSS_ADDR_OSC_STATUS);
wire hit_fs = (wb_adr_i == `CSS_ADDR_FREQ_SEL);
wire hit_sm = (wb_adr_i == `CSS_ADDR_SUPPLY_MODE);
wire hit_any = hit_om | hit_sc | hit_cs | hit_fs | hit_sm;
wire wr_lane0 = bus_req & wb_we_i & wb_sel_i[0];
// an 8-bit write is lane 0 alone; wider accesses leave the mode register alone
wire om_byte_wr = bus_req & wb_we_i & hit_om & (wb_sel_i == 4'h1);
wire [7:0] wd = wb_dat_i[7:0];
// codes past the 1 MHz entry name no oscillator setting; refusing them keeps
// the on-chip clock within the 1 to 32 MHz set
wire fs_code_ok = (wd[3:0] <= `CSS_FREQ_1);
wire opt_code_ok = (option_freq_i[3:0] <= `CSS_FREQ_1);

wire ext_clk_mode = osc_mode_reg[`CSS_OM_EXT_CLK_BIT];
wire osc_sel_mode = osc_mode_reg[`CSS_OM_OSC_SEL_BIT];
wire xtal_mode = ~ext_clk_mode & osc_sel_mode;
wire ext_mode = ext_clk_mode & osc_sel_mode;
wire cpu_on_hs = main_clk_status_reg;

// ----------------------------------------
// register writes
// ----------------------------------------
always @(posedge clk_i) begin
    if (rst_i) begin
        osc_mode_reg <= `CSS_OM_RESET;
        osc_mode_written_reg <= 1'b0;
        main_clk_select_reg <= 1'b0;
        hs_sys_clk_stop_reg <= 1'b1;
        onchip_hs_osc_stop_reg <= 1'b0;
        interval_timer_clk_select_reg <= 1'b0;
        freq_loaded_reg <= 1'b0;
        freq_sel_reg <= `CSS_FREQ_1;
    end else begin
        if (!freq_loaded_reg) begin
            if (opt_code_ok) begin
                freq_sel_reg <= option_freq_i[3:0];
            end
            freq_loaded_reg <= 1'b1;
        end
        if (om_byte_wr && !osc_mode_written_reg) begin
            osc_mode_reg <= wd & `CSS_OM_WMASK;
            osc_mode_written_reg <= 1'b1;
        end
        if (wr_lane0 && hit_sc) begin
            main_clk_select_reg <= wd[`CSS_SC_MAIN_SEL_BIT];
        end
        if (wr_lane0 && hit_cs) begin
            hs_sys_clk_stop_reg <= wd[`CSS_CS_HS_STOP_BIT];
            onchip_hs_osc_stop_reg <= wd[`CSS_CS_HOCO_STOP_BIT];
        end
        if (wr_lane0 && hit_fs && fs_code_ok) begin
            freq_sel_reg <= wd[3:0];
        end
        if (wr_lane0 && hit_sm) begin
            interval_timer_clk_select_reg <= wd[`CSS_SM_ITMR_CLK_BIT];
        end
    end
end

// ----------------------------------------
// bus answer: one-cycle ack, error on unmapped address
// ----------------------------------------
reg [7:0] rd_byte;
always @* begin
    rd_byte = 8'h00;
    if (hit_om) begin
        rd_byte = osc_mode_reg;
    end else if (hit_sc) begin
        rd_byte = {cpu_on_hs, 1'b0, main_clk_status_reg, main_clk_select_reg, 4'h0};
    end else if (hit_cs) begin
        rd_byte = {hs_sys_clk_stop_reg, 1'b1, 5'h00, onchip_hs_osc_stop_reg};
    end else if (hit_fs) begin
        rd_byte = {4'h0, freq_sel_reg};
    end else if (hit_sm) begin
        rd_byte = {3'h0, interval_timer_clk_select_reg, 4'h0};
    end
end

always @(posedge clk_i) begin
    if (rst_i) begin
        ack_reg <= 1'b0;
        err_reg <= 1'b0;
        rdata_reg <= 32'h00000000;
    end else begin
        ack_reg <= bus_req & hit_any;
        err_reg <= bus_req & ~hit_any;
        if (bus_req && hit_any && !wb_we_i) begin
            rdata_reg <= {24'h000000, rd_byte};
        end
    end
end

assign wb_ack_o = ack_reg;
assign wb_err_o = err_reg;
assign wb_dat_o = rdata_reg;

// ----------------------------------------
// settle flag from the oscillator's own domain
// ----------------------------------------
wire hs_ready_sync;
css_sync3 u_css_sync3 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(hs_clk_ready_i),
    .q_o(hs_ready_sync)
);

// ----------------------------------------
// main clock switch: gate, wait, change source, open
// ----------------------------------------
// the gate closes before the mux moves so no short pulse reaches the cpu
wire sw_want = (main_clk_select_reg != main_clk_status_reg);
wire sw_done = (sw_cnt_reg == SWITCH_CYC[7:0]);
wire target_ready = main_clk_select_reg ? (hs_ready_sync & ~hs_sys_clk_stop_reg)
                                        : ~onchip_hs_osc_stop_reg;

always @* begin
    sw_state_next = sw_state_reg;
    case (sw_state_reg)
        SW_IDLE: begin
            if (sw_want && target_ready) begin
                sw_state_next = SW_GATE;
            end
        end
        SW_GATE: begin
            if (sw_done) begin
                sw_state_next = SW_SETTLE;
            end
        end
        SW_SETTLE: begin
            if (sw_done) begin
                sw_state_next = SW_OPEN;
            end
        end
        SW_OPEN: begin
            sw_state_next = SW_IDLE;
        end
        default: begin
            sw_state_next = SW_IDLE;
        end
    endcase
end

always @(posedge clk_i) begin
    if (rst_i) begin
        sw_state_reg <= SW_IDLE;
        sw_cnt_reg <= 8'h00;
        main_clk_status_reg <= 1'b0;
        halted_reg <= 1'b0;
    end else begin
        sw_state_reg <= sw_state_next;
        if (sw_state_next != sw_state_reg) begin
            sw_cnt_reg <= 8'h00;
        end else if (!sw_done) begin
            sw_cnt_reg <= sw_cnt_reg + 8'h01;
        end
        if (sw_state_reg == SW_GATE && sw_done) begin
            main_clk_status_reg <= main_clk_select_reg;
        end
        halted_reg <= halt_exec_i | stop_exec_i;
    end
end

// ----------------------------------------
// oscillator enables and clock routing
// ----------------------------------------
assign crystal_osc_en_o = xtal_mode & ~hs_sys_clk_stop_reg & ~stop_exec_i;
assign ext_clk_in_en_o = ext_mode & ~hs_sys_clk_stop_reg & ~stop_exec_i;
assign crystal_osc_gain_o = osc_mode_reg[`CSS_OM_GAIN_BIT];
assign crystal_in_pin_port_o = ~(xtal_mode | ext_mode) | ext_mode;
assign crystal_out_pin_port_o = ~(xtal_mode | ext_mode);
assign onchip_hs_osc_en_o = ~onchip_hs_osc_stop_reg & ~stop_exec_i;
assign onchip_freq_o = freq_sel_reg;
assign main_clk_sel_hs_o = main_clk_status_reg;
// the low-speed oscillator has no path into the cpu mux
assign cpu_clk_gate_o = (sw_state_reg == SW_IDLE) | (sw_state_reg == SW_OPEN);

wire wdt_on = option_wdt_i[`CSS_OPT_WDT_EN_BIT];
wire wdt_stby = option_wdt_i[`CSS_OPT_WDT_STBY_BIT];
wire ls_halt_stop = wdt_on & ~interval_timer_clk_select_reg & ~wdt_stby & halted_reg;
assign lowspeed_osc_en_o = (wdt_on | interval_timer_clk_select_reg) & ~ls_halt_stop;
assign lowspeed_to_wdt_en_o = lowspeed_osc_en_o & wdt_on;
assign lowspeed_to_itmr_en_o = lowspeed_osc_en_o & interval_timer_clk_select_reg;

endmodule // css_clock_source_select

// ----------------------------------------
// three-stage synchroniser
// ----------------------------------------
// a level change is passed on only once the second and third stages agree,
// so a stage caught mid-transition never reaches the switch logic
module css_sync3 (
    input wire clk_i,
    input wire rst_i,
    input wire d_i,
    output wire q_o
);

reg [2:0] stage_reg;
reg q_reg;

always @(posedge clk_i) begin
    if (rst_i) begin
        stage_reg <= 3'h0;
        q_reg <= 1'b0;
    end else begin
        stage_reg <= {stage_reg[1:0], d_i};
        if (stage_reg[1] == stage_reg[2]) begin
            q_reg <= stage_reg[2];
        end
    end
end

assign q_o = q_reg;

endmodule // css_sync3

// File: verification/css_monitor.sv
// assertion checker for the clock source select block
`timescale 1ns/1ns
module css_monitor #(
    parameter SWITCH_CYC = 3
) (
    input wire clk_i,
    input wire rst_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    input wire wb_err_o,
    input wire [7:0] option_wdt_i,
    input wire stop_exec_i,
    input wire crystal_osc_en_o,
    input wire ext_clk_in_en_o,
    input wire onchip_hs_osc_en_o,
    input wire crystal_in_pin_port_o,
    input wire crystal_out_pin_port_o,
    input wire lowspeed_osc_en_o,
    input wire main_clk_sel_hs_o,
    input wire cpu_clk_gate_o
);
    // two guarded phases and one open cycle, with some slack
    localparam int GATE_MAX = 2 * SWITCH_CYC + 8;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    AST_ANSWER: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
        |=> wb_ack_o ^ wb_err_o) else $error("request not answered once");
    AST_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    AST_BOOT: assert property ($fell(rst_i) |-> cpu_clk_gate_o && !main_clk_sel_hs_o)
        else $error("cpu not on on-chip clock after reset");
    AST_XSTOP: assert property (stop_exec_i |-> !crystal_osc_en_o && !ext_clk_in_en_o)
        else $error("high-speed source alive in stop");
    AST_HSTOP: assert property (stop_exec_i |-> !onchip_hs_osc_en_o)
        else $error("on-chip oscillator alive in stop");
    AST_PINS: assert property (crystal_osc_en_o |-> !crystal_in_pin_port_o
        && !crystal_out_pin_port_o) else $error("crystal pins left as ports");
    AST_EXT: assert property (ext_clk_in_en_o |-> crystal_in_pin_port_o
        && !crystal_out_pin_port_o && !crystal_osc_en_o) else $error("external mode pins wrong");
    AST_LOW: assert property (option_wdt_i[4] && option_wdt_i[0] |-> lowspeed_osc_en_o)
        else $error("low-speed oscillator stopped");
    AST_GLITCH: assert property ($changed(main_clk_sel_hs_o) |-> !cpu_clk_gate_o)
        else $error("source changed with cpu clock open");
    AST_REOPEN: assert property ($fell(cpu_clk_gate_o) |-> ##[1:GATE_MAX] cpu_clk_gate_o)
        else $error("cpu clock stays gated");
    cover property ($rose(main_clk_sel_hs_o));
    cover property (ext_clk_in_en_o);
    cover property (wb_err_o);
endmodule // css_monitor

bind css_clock_source_select css_monitor #(.SWITCH_CYC(SWITCH_CYC)) u_css_monitor (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .option_wdt_i(option_wdt_i),
    .stop_exec_i(stop_exec_i), .crystal_osc_en_o(crystal_osc_en_o),
    .ext_clk_in_en_o(ext_clk_in_en_o), .onchip_hs_osc_en_o(onchip_hs_osc_en_o),
    .crystal_in_pin_port_o(crystal_in_pin_port_o),
    .crystal_out_pin_port_o(crystal_out_pin_port_o),
    .lowspeed_osc_en_o(lowspeed_osc_en_o), .main_clk_sel_hs_o(main_clk_sel_hs_o),
    .cpu_clk_gate_o(cpu_clk_gate_o));

// File: verification/css_xtal_model.sv
// behavioural crystal or external clock source driving the settled flag
`timescale 1ns/1ns
module css_xtal_model #(
    parameter STAB = 4
) (
    input wire clk_i,
    input wire osc_en_i,
    output logic ready_o
);
    int cnt = 0;
    // never ready at once: each start needs settling time
    always @(posedge clk_i) begin
        if (!osc_en_i) begin
            cnt <= 0;
        end else if (cnt < STAB) begin
            cnt <= cnt + 1;
        end
    end
    assign ready_o = (cnt == STAB);
endmodule // css_xtal_model

// File: verification/css_clock_source_select_tb.sv
// self-checking bench for the clock source select block
`timescale 1ns/1ns
`include "css_consts.vh"
`define CSS_CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin n_mismatch++; \
    $display("MISMATCH %s exp %h got %h", nm, e, a); end end
module css_clock_source_select_tb;
    localparam [19:0] a_mode = `CSS_ADDR_OSC_MODE;
    localparam [19:0] a_sel = `CSS_ADDR_SYS_CLK_SEL;
    localparam [19:0] a_stat = `CSS_ADDR_OSC_STATUS;
    int checked = 0;
    int n_mismatch = 0;
    logic clk_i = 1'h0, rst_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
    logic [19:0] wb_adr_i = 20'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [7:0] option_freq_i = 8'h03, option_wdt_i = 8'h00, q;
    logic stop_exec_i = 1'h0, halt_exec_i = 1'h0, e;
    wire hs_clk_ready_i;
    wire [31:0] wb_dat_o;
    wire [3:0] onchip_freq_o;
    wire wb_ack_o, wb_err_o, crystal_osc_en_o, crystal_osc_gain_o, crystal_in_pin_port_o;
    wire crystal_out_pin_port_o, ext_clk_in_en_o, onchip_hs_osc_en_o, lowspeed_osc_en_o;
    wire lowspeed_to_wdt_en_o, lowspeed_to_itmr_en_o, main_clk_sel_hs_o, cpu_clk_gate_o;
    css_clock_source_select #(.SWITCH_CYC(1)) u_css_clock_source_select (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
        .option_freq_i(option_freq_i), .option_wdt_i(option_wdt_i),
        .stop_exec_i(stop_exec_i), .halt_exec_i(halt_exec_i), .hs_clk_ready_i(hs_clk_ready_i),
        .crystal_osc_en_o(crystal_osc_en_o), .crystal_osc_gain_o(crystal_osc_gain_o),
        .crystal_in_pin_port_o(crystal_in_pin_port_o),
        .crystal_out_pin_port_o(crystal_out_pin_port_o),
        .ext_clk_in_en_o(ext_clk_in_en_o), .onchip_hs_osc_en_o(onchip_hs_osc_en_o),
        .onchip_freq_o(onchip_freq_o), .lowspeed_osc_en_o(lowspeed_osc_en_o),
        .lowspeed_to_wdt_en_o(lowspeed_to_wdt_en_o),
        .lowspeed_to_itmr_en_o(lowspeed_to_itmr_en_o),
        .main_clk_sel_hs_o(main_clk_sel_hs_o), .cpu_clk_gate_o(cpu_clk_gate_o));
    css_xtal_model u_css_xtal_model (.clk_i(clk_i),
        .osc_en_i(crystal_osc_en_o | ext_clk_in_en_o), .ready_o(hs_clk_ready_i));
    initial forever #50 clk_i = ~clk_i;
    task automatic bus(input logic w, input logic [19:0] a, input logic [3:0] s,
                       input logic [7:0] d);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= {24'h0, d};
        do begin
            @(posedge clk_i);
        end while (!(wb_ack_o || wb_err_o));
        `CSS_CHK("answer", 1'h1, wb_ack_o ^ wb_err_o)
        q = wb_dat_o[7:0];
        e = wb_err_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        bus(1'h1, a, 4'h1, d);
    endtask
    task automatic rdc(input logic [19:0] a, input logic [7:0] x);
        bus(1'h0, a, 4'h1, 8'h00);
        `CSS_CHK("register", x, q)
    endtask
    task automatic sw(input logic [7:0] d, input logic [7:0] x);
        int n;
        n = 0;
        wr(a_sel, d);
        `CSS_CHK("gate", 1'h0, cpu_clk_gate_o)
        while (cpu_clk_gate_o !== 1'h1 && n < 40) begin
            @(posedge clk_i);
            n++;
        end
        `CSS_CHK("reopen", 1'h1, cpu_clk_gate_o)
        `CSS_CHK("mux", d[4], main_clk_sel_hs_o)
        rdc(a_sel, x);
    endtask
    task automatic t_boot;
        rdc(a_stat, `CSS_CS_RESET);
        rdc(a_sel, `CSS_SC_RESET);
        `CSS_CHK("freq", 4'h3, onchip_freq_o)
        `CSS_CHK("crystal", 1'h0, crystal_osc_en_o)
        wr(a_sel, 8'ha0);
        rdc(a_sel, 8'h00);
        wr(`CSS_ADDR_FREQ_SEL, 8'h09);
        `CSS_CHK("freq", 4'h9, onchip_freq_o)
        wr(`CSS_ADDR_FREQ_SEL, 8'h04);
        `CSS_CHK("freq", 4'h4, onchip_freq_o)
        wr(`CSS_ADDR_FREQ_SEL, 8'h0f);
        `CSS_CHK("freq", 4'h4, onchip_freq_o)
        wr(`CSS_ADDR_FREQ_SEL, 8'h00);
        `CSS_CHK("freq", 4'h0, onchip_freq_o)
        bus(1'h0, 20'hfffb4, 4'h1, 8'h00);
        `CSS_CHK("unmapped", 1'h1, e)
        $display("t_boot done");
    endtask
    task automatic t_mode;
        bus(1'h1, a_mode, 4'hf, 8'h41);
        rdc(a_mode, 8'h00);
        wr(a_mode, 8'h41);
        rdc(a_mode, 8'h41);
        `CSS_CHK("gain", 1'h1, crystal_osc_gain_o)
        wr(a_mode, 8'h00);
        rdc(a_mode, 8'h41);
        wr(a_stat, 8'h40);
        `CSS_CHK("crystal", 1'h1, crystal_osc_en_o)
        `CSS_CHK("in pin", 1'h0, crystal_in_pin_port_o)
        stop_exec_i <= 1'h1;
        @(posedge clk_i);
        `CSS_CHK("crystal", 1'h0, crystal_osc_en_o)
        `CSS_CHK("on-chip", 1'h0, onchip_hs_osc_en_o)
        stop_exec_i <= 1'h0;
        repeat (8) @(posedge clk_i);
        $display("t_mode done");
    endtask
    task automatic t_switch;
        sw(8'h10, 8'hb0);
        sw(8'h00, 8'h00);
        $display("t_switch done");
    endtask
    task automatic t_low;
        option_wdt_i <= 8'h10;
        @(posedge clk_i);
        `CSS_CHK("low", 1'h1, lowspeed_osc_en_o)
        halt_exec_i <= 1'h1;
        repeat (3) @(posedge clk_i);
        `CSS_CHK("low", 1'h0, lowspeed_osc_en_o)
        wr(`CSS_ADDR_SUPPLY_MODE, 8'h10);
        `CSS_CHK("timer clk", 1'h1, lowspeed_to_itmr_en_o)
        `CSS_CHK("wdt clk", 1'h1, lowspeed_to_wdt_en_o)
        `CSS_CHK("low", 1'h1, lowspeed_osc_en_o)
        option_wdt_i <= 8'h11;
        halt_exec_i <= 1'h0;
        @(posedge clk_i);
        $display("t_low done");
    endtask
    task automatic t_ext;
        rst_i <= 1'h1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        rdc(a_mode, 8'h00);
        `CSS_CHK("in pin", 1'h1, crystal_in_pin_port_o)
        wr(a_mode, 8'hc0);
        wr(a_stat, 8'h40);
        `CSS_CHK("ext", 1'h1, ext_clk_in_en_o)
        `CSS_CHK("out pin", 1'h0, crystal_out_pin_port_o)
        wr(a_stat, 8'hc0);
        `CSS_CHK("ext", 1'h0, ext_clk_in_en_o)
        $display("t_ext done");
    endtask
    task automatic t_lock;
        rst_i <= 1'h1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        wr(a_mode, 8'h00);
        `CSS_CHK("freq", 4'h3, onchip_freq_o)
        wr(a_mode, 8'hc1);
        rdc(a_mode, 8'h00);
        `CSS_CHK("out pin", 1'h1, crystal_out_pin_port_o)
        $display("t_lock done");
    endtask
    task test_done;
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        #400000;
        n_mismatch++;
        test_done;
    end
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        t_boot;
        t_mode;
        t_switch;
        t_low;
        t_ext;
        t_lock;
        test_done;
    end
endmodule // css_clock_source_select_tb
